// ---- include/sdclt_pkg.sv ----
package sdclt_pkg;
  // Command codes on {ras_n, cas_n, we_n} while chip select is low
  localparam logic [2:0] CMD_MODE_SET = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_BURST_STOP = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Mode word fields on the address bus
  localparam int MODE_BURST_LSB = 0;
  localparam int MODE_CAS_LSB = 4;
  // Reset values of the mode settings
  localparam logic [1:0] CAS_LATENCY_RST = 2'h3;
  localparam logic [3:0] BURST_LENGTH_RST = 4'h1;
  // Fixed latencies in clock cycles
  localparam int CKE_LATENCY = 1;
  localparam int READ_MASK_LATENCY = 2;
  localparam int WRITE_MASK_LATENCY = 0;
  localparam int WRITE_DATA_LATENCY = 0;
  localparam int CS_LATENCY = 0;
endpackage

// ---- rtl/sdclt_core.sv ----
`timescale 1ns/100ps
// Behaviour
// - Internal clock stops one cycle after cke low
// - Read mask floats lanes two cycles later
// - Write mask blocks data same cycle
// - Command taken in chip select cycle
// - Precharge floats outputs after cas_latency cycles
// - Precharge: last word cas_latency-1 cycles later
// - Burst stop floats outputs after cas_latency
// - Burst stop: last word cas_latency-1 later
module sdclt_core
  import sdclt_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int COL_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command inputs
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [COL_W-1:0] addr,
  // Data lanes
  input wire logic [DATA_W/8-1:0] dqm,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W/8-1:0] dq_oe
);
  localparam int LANES = DATA_W / 8;
  localparam int DEPTH = 1 << COL_W;

  logic run_reg;
  logic [2:0] cmd;
  logic read_cmd, write_cmd, kill_cmd, mode_cmd;
  logic [1:0] cas_latency_reg;
  logic [3:0] burst_length_reg, burst_length_next;
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic pick_s1;
  logic rd_active_reg, wr_active_reg;
  logic [3:0] rd_left_reg, wr_left_reg;
  logic [COL_W-1:0] rd_col_reg, wr_col_reg, gen_col, wr_col;
  logic gen_valid, wr_go;
  logic [LANES-1:0] lane_we;
  logic s1_valid_reg, s2_valid_reg;
  logic [DATA_W-1:0] s1_data_reg, s2_data_reg, dq_out_reg;
  logic [LANES-1:0] dqm_d1_reg, dq_oe_reg;

  // Internal clock enable lags cke by one cycle; this flop always runs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_reg <= 1'b1;
    end else begin
      run_reg <= cke;
    end
  end

  // Deselect reads as no operation in the same cycle
  assign cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
  assign read_cmd = run_reg && cmd == CMD_READ;
  assign write_cmd = run_reg && cmd == CMD_WRITE;
  assign mode_cmd = run_reg && cmd == CMD_MODE_SET;
  assign kill_cmd = run_reg &&
                    (cmd == CMD_PRECHARGE || cmd == CMD_BURST_STOP);

  always_comb begin
    case (addr[MODE_BURST_LSB +: 2])
      2'h0: burst_length_next = 4'h1;
      2'h1: burst_length_next = 4'h2;
      2'h2: burst_length_next = 4'h4;
      default: burst_length_next = 4'h8;
    endcase
  end

  // Only latencies 2 and 3 exist; anything else falls back to 3
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cas_latency_reg <= CAS_LATENCY_RST;
      burst_length_reg <= BURST_LENGTH_RST;
    end else if (mode_cmd) begin
      cas_latency_reg <= (addr[MODE_CAS_LSB +: 2] == 2'h2) ? 2'h2 : 2'h3;
      burst_length_reg <= burst_length_next;
    end
  end

  // Read burst generator; a stop takes effect in its own cycle
  assign gen_valid = read_cmd ||
                     (run_reg && rd_active_reg && !kill_cmd && !write_cmd);
  assign gen_col = read_cmd ? addr : rd_col_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_active_reg <= 1'b0;
      rd_left_reg <= 4'h0;
      rd_col_reg <= '0;
    end else if (read_cmd) begin
      rd_active_reg <= burst_length_reg > 4'h1;
      rd_left_reg <= burst_length_reg - 4'h1;
      rd_col_reg <= addr + COL_W'(1);
    end else if (gen_valid) begin
      rd_active_reg <= rd_left_reg > 4'h1;
      rd_left_reg <= rd_left_reg - 4'h1;
      rd_col_reg <= rd_col_reg + COL_W'(1);
    end else if (kill_cmd || write_cmd) begin
      rd_active_reg <= 1'b0;
    end
  end

  // Write burst: first word is taken with the command itself
  assign wr_go = write_cmd ||
                 (run_reg && wr_active_reg && !kill_cmd && !read_cmd);
  assign wr_col = write_cmd ? addr : wr_col_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_active_reg <= 1'b0;
      wr_left_reg <= 4'h0;
      wr_col_reg <= '0;
    end else if (write_cmd) begin
      wr_active_reg <= burst_length_reg > 4'h1;
      wr_left_reg <= burst_length_reg - 4'h1;
      wr_col_reg <= addr + COL_W'(1);
    end else if (wr_go) begin
      wr_active_reg <= wr_left_reg > 4'h1;
      wr_left_reg <= wr_left_reg - 4'h1;
      wr_col_reg <= wr_col_reg + COL_W'(1);
    end else if (kill_cmd || read_cmd) begin
      wr_active_reg <= 1'b0;
    end
  end

  // Lanes whose mask is high keep their old contents
  assign lane_we = {LANES{wr_go}} & ~dqm;

  // One process per entry, so every word has a single driver
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          mem_reg[g] <= '0;
        end else if (wr_col == COL_W'(g)) begin
          for (int ln = 0; ln < LANES; ln++) begin
            if (lane_we[ln]) begin
              mem_reg[g][ln*8 +: 8] <= dq_in[ln*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // Output pipeline; the output flop picks the stage by cas_latency
  assign pick_s1 = cas_latency_reg == 2'h2;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_valid_reg <= 1'b0;
      s2_valid_reg <= 1'b0;
      s1_data_reg <= '0;
      s2_data_reg <= '0;
      dq_out_reg <= '0;
      dq_oe_reg <= '0;
      dqm_d1_reg <= '0;
    end else if (run_reg) begin
      s1_valid_reg <= gen_valid;
      s1_data_reg <= mem_reg[gen_col];
      s2_valid_reg <= s1_valid_reg;
      s2_data_reg <= s1_data_reg;
      dqm_d1_reg <= dqm;
      dq_out_reg <= pick_s1 ? s1_data_reg : s2_data_reg;
      // Mask sampled one cycle back lands two cycles after it was seen
      dq_oe_reg <= {LANES{pick_s1 ? s1_valid_reg : s2_valid_reg}}
                   & ~dqm_d1_reg;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe = dq_oe_reg;

  cke_stop_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !cke |=> !run_reg)
    else $error("internal clock not stopped after cke low");

  freeze_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !run_reg |=> $stable(dq_oe_reg) && $stable(rd_left_reg))
    else $error("state changed while clock suspended");

  read_mask_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    run_reg && dqm[0] ##1 run_reg |=> !dq_oe[0])
    else $error("read mask did not float lane two cycles later");

  write_mask_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_go && dqm[LANES-1] && wr_col == '0
    |=> $stable(mem_reg[0][(LANES-1)*8 +: 8]))
    else $error("masked write lane was written");

  cs_take_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    run_reg && !cs_n && !ras_n && !cas_n && !we_n &&
    addr[MODE_CAS_LSB +: 2] == 2'h2 |=> cas_latency_reg == 2'h2)
    else $error("command not taken in chip select cycle");

  cs_take3_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    run_reg && !cs_n && !ras_n && !cas_n && !we_n &&
    addr[MODE_CAS_LSB +: 2] != 2'h2 |=> cas_latency_reg == 2'h3)
    else $error("command not taken in chip select cycle");

  cs_skip_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    run_reg && cs_n
    |=> $stable(cas_latency_reg) && $stable(burst_length_reg))
    else $error("deselected command was taken");

  stop_float2_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    kill_cmd && cas_latency_reg == 2'h2 ##1 run_reg |=> dq_oe == '0)
    else $error("outputs not floated two cycles after stop");

  stop_float3_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    kill_cmd && cas_latency_reg == 2'h3 ##1 run_reg && !mode_cmd ##1 run_reg
    |=> dq_oe == '0)
    else $error("outputs not floated three cycles after stop");

  last_word_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    run_reg && dqm == '0 ##1
    kill_cmd && rd_active_reg && cas_latency_reg == 2'h2 |=> dq_oe == '1)
    else $error("word before stop not delivered");

  last_word3_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    run_reg ##1
    kill_cmd && rd_active_reg && cas_latency_reg == 2'h3 && dqm == '0
    ##1 run_reg |=> dq_oe == '1)
    else $error("word before stop not delivered");

  no_gen_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    kill_cmd |=> !s1_valid_reg)
    else $error("burst continued after stop");
endmodule

// ---- sim/sdclt_ctrl_model.sv ----
`timescale 1ns/100ps
module sdclt_ctrl_model
  import sdclt_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Command
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [7:0] addr,
  // Data
  output logic [1:0] dqm,
  output logic [15:0] dq_in
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = CMD_NOP;
    addr = 8'h00;
    dqm = 2'h0;
    dq_in = 16'h0000;
  end
  // Mode set needs 14 ns at most, under one 25 ns cycle
  task automatic send(input logic s, input logic [2:0] c,
      input logic [7:0] a, input logic [1:0] m, input logic [15:0] d);
    @(negedge ref_clk);
    cs_n = s;
    cmd = c;
    addr = a;
    dqm = m;
    dq_in = d;
  endtask
  // Idle lanes toggle so stale data never looks valid
  // Idle cycles are deselected; their random codes must be ignored
  task automatic rest(input int n);
    repeat (n) send(1'b1, 3'($urandom()), 8'($urandom()), 2'h0, ~dq_in);
  endtask
  // No activate, refresh or self refresh is sent
endmodule

// ---- sim/sdram_command_latency_timing_test.sv ----
`timescale 1ns/100ps
module sdram_command_latency_timing_test;
  import sdclt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cke;
  logic cs_n;
  logic [2:0] cmd;
  logic [7:0] addr;
  logic [1:0] dqm;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [1:0] dq_oe;
  logic [15:0] mem [256];
  logic [49:0] notes [$];
  logic [15:0] w [2];
  logic [1:0] m;
  int cyc = 0;
  int e = 0;
  int miscompares = 0;
  int n_checks = 0;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  sdclt_ctrl_model ctl_u (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
    .cmd(cmd), .addr(addr), .dqm(dqm), .dq_in(dq_in));
  sdclt_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cke(cke),
    .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  function automatic logic [15:0] lanes(input logic [1:0] oe);
    return {{8{oe[1]}}, {8{oe[0]}}};
  endfunction

  task automatic cmp_word(input logic [49:0] got, input logic [49:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Notes hold {cycle, lane enables, data} so latency is checked too
  // A value shown now is sampled by the far side at the next rising edge
  always @(negedge ref_clk) begin
    if (rst_n && dq_oe !== 2'h0) begin
      if (notes.size() == 0)
        cmp_word({32'(cyc + 1), dq_oe, dq_out}, 50'h0);
      else
        cmp_word({32'(cyc + 1), dq_oe, dq_out & lanes(dq_oe)},
          notes.pop_front());
    end
  end

  task automatic go(input logic [2:0] c, input logic [7:0] a,
      input logic [1:0] m);
    ctl_u.send(1'b0, c, a, m, w[0]);
    e = cyc + 1;
  endtask

  task automatic expect_rd(input logic [7:0] a, input int lat, input int n,
      input logic [1:0] oe1);
    logic [1:0] oe;
    for (int i = 0; i < n; i++) begin
      oe = (i == 1) ? oe1 : 2'h3;
      notes.push_back({32'(e + lat + i), oe, mem[8'(a + i)] & lanes(oe)});
    end
  endtask

  task automatic finish_test();
    cmp_word(50'(notes.size()), 50'h0);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    w[0] = 16'($urandom(80));
    w[1] = 16'($urandom());
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    go(CMD_MODE_SET, 8'h21, 2'h0);
    go(CMD_WRITE, 8'hFF, 2'h0);
    ctl_u.send(1'b1, CMD_NOP, 8'h00, 2'h2, w[1]);
    mem[8'hFF] = w[0];
    mem[8'h00][7:0] = w[1][7:0];
    ctl_u.rest(2);
    ctl_u.send(1'b1, CMD_WRITE, 8'h10, 2'h0, ~w[0]);
    ctl_u.cke = 1'b0;
    ctl_u.send(1'b0, CMD_WRITE, 8'h11, 2'h0, ~w[1]);
    ctl_u.rest(1);
    ctl_u.cke = 1'b1;
    ctl_u.rest(2);
    go(CMD_READ, 8'h10, 2'h0);
    expect_rd(8'h10, 2, 2, 2'h3);
    ctl_u.rest(4);
    m = 2'($urandom_range(2, 1));
    go(CMD_READ, 8'hFF, 2'h0);
    expect_rd(8'hFF, 2, 2, ~m);
    ctl_u.send(1'b1, CMD_NOP, 8'h00, m, ~w[0]);
    ctl_u.rest(4);
    go(CMD_MODE_SET, 8'h23, 2'h0);
    go(CMD_READ, 8'hFE, 2'h0);
    expect_rd(8'hFE, 2, 2, 2'h3);
    ctl_u.rest(1);
    go(CMD_PRECHARGE, 8'h00, 2'h0);
    ctl_u.rest(12);
    go(CMD_MODE_SET, 8'h03, 2'h0);
    go(CMD_READ, 8'hFF, 2'h0);
    expect_rd(8'hFF, 3, 2, 2'h3);
    ctl_u.rest(1);
    go(CMD_BURST_STOP, 8'h00, 2'h0);
    ctl_u.rest(12);
    finish_test();
  end
endmodule
